// file: rtl/aum_pkg.sv
package aum_pkg;

   // register byte offsets
   localparam logic [11:0] STATUS_OFF = 12'h104;
   localparam logic [11:0] MASK_OFF = 12'h108;
   localparam logic [11:0] CTRL_OFF = 12'h200;
   localparam logic [11:0] FEP_OFF = 12'h204;
   localparam logic [11:0] HDR_OFF = 12'h208;

   // bit positions shared by status and mask, plus the control register enable bit
   localparam int BIT_UNUSED0 = 0;
   localparam int BIT_LINK = 4;
   localparam int BIT_SDOWN = 5;
   localparam int BIT_POISON = 12;
   localparam int BIT_FCERR = 13;
   localparam int BIT_CTO = 14;
   localparam int BIT_COMPLETER_ABORT_FLAG = 15;
   localparam int BIT_UNEXP = 16;
   localparam int BIT_INTERR = 22;
   localparam int BIT_MCBLK = 23;
   localparam int BIT_ATOMIC = 24;
   localparam int BIT_PREFIX = 25;
   localparam int BIT_CTRL_IEEN = 0;

   // field layouts
   localparam logic [31:0] STATUS_IMPL = 32'h0041_5011;
   localparam logic [31:0] MASK_RW = 32'h0001_5011;
   localparam logic [31:0] MASK_STICKY = 32'h0001_1011;
   localparam int FEP_W = 5;

   // reset values
   localparam logic [31:0] STATUS_RST = 32'h0000_0000;
   localparam logic [31:0] MASK_RST = 32'h0000_0000;
   localparam logic [31:0] HDR_RST = 32'h0000_0000;
   localparam logic [4:0] FEP_RST = 5'h00;
   localparam logic CTRL_IEEN_RST = 1'b0;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // error detector input: one hit bit per status position plus header
   typedef struct packed {
      logic [31:0] hit;
      logic [31:0] header;
   } aum_err_t;

   // report toward the root-complex messaging logic
   typedef struct packed {
      logic valid;
      logic [4:0] pointer;
   } aum_report_t;

endpackage : aum_pkg

// file: rtl/aum_axil_slave.sv
`timescale 1ns/1ps
module aum_axil_slave
   import aum_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wrReq,
   output logic [ADDR_W-1:0] wrAddr,
   output logic [31:0] wrData,
   output logic [3:0] wrStrb,
   input wire logic wrHit,
   output logic rdReq,
   output logic [ADDR_W-1:0] rdAddr,
   input wire logic [31:0] rdData,
   input wire logic rdHit
);

   // both write channels held and no response pending
   assign wrReq = !awready && !wready && !bvalid;
   assign rdReq = !arready && !rvalid;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         wrAddr <= '0;
         wrData <= 32'h0000_0000;
         wrStrb <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            wrAddr <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            wrData <= wdata;
            wrStrb <= wstrb;
            wready <= 1'b0;
         end
         if (wrReq) begin
            bvalid <= 1'b1;
            bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rresp <= RESP_OKAY;
         rdata <= 32'h0000_0000;
         rdAddr <= '0;
      end else begin
         if (arvalid && arready) begin
            rdAddr <= araddr;
            arready <= 1'b0;
         end
         if (rdReq) begin
            rvalid <= 1'b1;
            rdata <= rdHit ? rdData : 32'h0000_0000;
            rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

endmodule : aum_axil_slave

// file: rtl/aum_regs.sv
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
// Summary of operation
// (R1) internal-error status bit 22 sets on detected internal error; W1C, zero; it clears once hot reset clears the enable.
// (R2) with internal-error reporting disabled, status bit 22 is read-only zero.
// (R3) multicast-blocked status bit 23 reads zero, writes ignored.
// (R4) atomic-egress and prefix-blocked status bits 24, 25 read zero.
// (R5) masked errors never load the header log.
// (R6) masked errors leave the first-error pointer unchanged.
// (R7) masked errors are never reported toward the root complex.
// (R8) status bits set on error regardless of the mask.
// (R9) mask bit 4 is read/write, sticky, resets to zero.
// (R10) mask bits 12 and 16 are read/write, sticky, reset to zero.
// (R11) mask bit 14 is read/write, resets to zero, not sticky.
// (R12) mask bits 5, 13, 15 read zero, writes ignored.
// (R13) mask bit 0 is read/write, sticky, zero at reset; it masks status bit 0.
// (R14) status bit 4 sets on link protocol error; W1C, sticky, zero.
// (R15) sticky bits survive hot reset; reserved bits read zero, ignore writes.
module aum_regs
   import aum_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic hotRst,
   input wire aum_err_t errIn,
   output aum_report_t errReport,
   output logic irq,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);

   generate
      if (ADDR_W < 12) begin : g_bad_width
         $error("aum_regs: ADDR_W must be at least 12");
      end
   endgenerate

   logic wrReq;
   logic [ADDR_W-1:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic wrHit;
   logic rdReq;
   logic [ADDR_W-1:0] rdAddr;
   logic [31:0] rdData;
   logic rdHit;

   logic [31:0] status;
   logic [31:0] mask;
   logic intErrEnable;
   logic [FEP_W-1:0] firstErrPtr;
   logic [31:0] headerLog;

   logic [31:0] next_status;
   logic [31:0] next_mask;
   logic [31:0] byteMask;
   logic [31:0] wrBits;
   logic [31:0] hitMask;
   logic [31:0] hit;
   logic [31:0] unmaskedHit;
   logic pending;

   aum_axil_slave #(
      .ADDR_W(ADDR_W)
   ) u_bus (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .wrReq(wrReq),
      .wrAddr(wrAddr),
      .wrData(wrData),
      .wrStrb(wrStrb),
      .wrHit(wrHit),
      .rdReq(rdReq),
      .rdAddr(rdAddr),
      .rdData(rdData),
      .rdHit(rdHit)
   );

   function automatic logic [FEP_W-1:0] lowest_bit(input logic [31:0] v);
      logic [FEP_W-1:0] idx;
      idx = '0;
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) begin
            idx = FEP_W'(i);
         end
      end
      return idx;
   endfunction : lowest_bit

   // byte lanes of the write strobe
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++) begin : g_lane
         assign byteMask[gb*8 +: 8] = {8{wrStrb[gb]}};
      end
   endgenerate

   assign wrBits = wrData & byteMask;

   function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                    input logic [11:0] off);
      return a == ADDR_W'(off);
   endfunction : addr_is

   always_comb begin
      wrHit = addr_is(wrAddr, STATUS_OFF) || addr_is(wrAddr, MASK_OFF) ||
              addr_is(wrAddr, CTRL_OFF) || addr_is(wrAddr, FEP_OFF) ||
              addr_is(wrAddr, HDR_OFF);
   end

   // unimplemented positions (23..25, reserved) can never set
   always_comb begin
      hitMask = STATUS_IMPL;
      hitMask[BIT_INTERR] = intErrEnable; // see R2
   end

   assign hit = errIn.hit & hitMask; // see R3 see R4
   assign unmaskedHit = hit & ~mask;
   assign pending = |(status & ~mask);

   // a new error wins over a clear landing in the same cycle
   always_comb begin
      next_status = status;
      if (wrReq && addr_is(wrAddr, STATUS_OFF)) begin
         next_status = next_status & ~(wrBits & STATUS_IMPL); // see R15
      end
      next_status = next_status | hit; // see R1 see R8 see R14
      if (!intErrEnable) begin
         next_status[BIT_INTERR] = 1'b0; // see R2
      end
   end

   // status ignores hot reset except bit 22, which drops once hot reset clears the enable; only the fundamental reset clears it
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         status <= STATUS_RST;
      end else begin
         status <= next_status;
      end
   end

   always_comb begin
      next_mask = mask;
      if (wrReq && addr_is(wrAddr, MASK_OFF)) begin
         // only the writable positions take data
         next_mask = (mask & ~(byteMask & MASK_RW)) |
                     (wrBits & MASK_RW); // see R9 see R10 see R12 see R13
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mask <= MASK_RST;
      end else if (hotRst) begin
         // hot reset drops the non-sticky timeout mask, writes ignored
         mask <= mask & MASK_STICKY; // see R11 see R15
      end else begin
         mask <= next_mask; // see R11
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst || hotRst) begin
         intErrEnable <= CTRL_IEEN_RST;
      end else if (wrReq && addr_is(wrAddr, CTRL_OFF) && wrStrb[0]) begin
         intErrEnable <= wrData[BIT_CTRL_IEEN];
      end
   end

   // first unmasked error since the log went idle loads pointer and header
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         firstErrPtr <= FEP_RST;
         headerLog <= HDR_RST;
      end else if ((|unmaskedHit) && !pending) begin
         firstErrPtr <= lowest_bit(unmaskedHit); // see R6
         headerLog <= errIn.header; // see R5
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         errReport <= '0;
      end else begin
         errReport.valid <= |unmaskedHit; // see R7
         errReport.pointer <= lowest_bit(unmaskedHit);
      end
   end

   // level interrupt; the AER mask doubles as the interrupt mask
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= pending; // see R7
      end
   end

   always_comb begin
      rdHit = 1'b1;
      unique case (1'b1)
         addr_is(rdAddr, STATUS_OFF): rdData = status; // see R3 see R4
         addr_is(rdAddr, MASK_OFF): rdData = mask & MASK_RW; // see R12
         addr_is(rdAddr, CTRL_OFF): rdData = 32'(intErrEnable);
         addr_is(rdAddr, FEP_OFF): rdData = 32'(firstErrPtr);
         addr_is(rdAddr, HDR_OFF): rdData = headerLog;
         default: begin
            rdData = 32'h0000_0000;
            rdHit = 1'b0;
         end
      endcase
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_masked_hit;
      ((errIn.hit & STATUS_IMPL & mask) != 32'h0000_0000) &&
      ((hit & ~mask) == 32'h0000_0000);
   endsequence

   sequence s_no_status_write;
      !(wrReq && addr_is(wrAddr, STATUS_OFF));
   endsequence

   // neither a detector hit nor a clear moves status; bit 22 still drops after the enable goes low
   sequence s_quiet;
      (hit == 32'h0000_0000) ##0 s_no_status_write;
   endsequence

   a_internal_set: assert property ( // see R1
      intErrEnable && errIn.hit[BIT_INTERR] |=> status[BIT_INTERR])
      else $error("internal error did not set its status bit");

   a_internal_gated: assert property ( // see R2
      !intErrEnable |=> !status[BIT_INTERR])
      else $error("internal error status set while reporting disabled");

   a_upper_zero: assert property ( // see R3
      status[BIT_MCBLK] == 1'b0)
      else $error("multicast blocked status not zero");

   a_egress_zero: assert property ( // see R4
      status[BIT_PREFIX:BIT_ATOMIC] == 2'b00 && status[31:26] == 6'h00)
      else $error("atomic or prefix blocked status not zero");

   a_header_hold: assert property ( // see R5
      s_masked_hit |=> $stable(headerLog))
      else $error("header log loaded by a masked error");

   a_pointer_hold: assert property ( // see R6
      s_masked_hit |=> $stable(firstErrPtr))
      else $error("first error pointer moved on a masked error");

   a_no_report: assert property ( // see R7
      s_masked_hit |=> !errReport.valid)
      else $error("masked error was reported");

   // a mask write in the hit cycle may legally hide the bit before irq
   a_report_path: assert property ( // see R7
      (hit[BIT_POISON] && !mask[BIT_POISON] &&
       !(wrReq && addr_is(wrAddr, MASK_OFF))) |=> errReport.valid ##1 irq)
      else $error("unmasked error not reported then flagged");

   a_masked_logged: assert property ( // see R8
      (errIn.hit[BIT_LINK] && mask[BIT_LINK]) |=> status[BIT_LINK])
      else $error("masked error did not set its status bit");

   a_set_wins: assert property ( // see R8
      (hit != 32'h0000_0000) |=> (status & $past(hit)) == $past(hit))
      else $error("error hit lost against a same cycle clear");

   a_status_clear: assert property ( // see R14
      (wrReq && addr_is(wrAddr, STATUS_OFF) && wrBits[BIT_LINK] &&
       !hit[BIT_LINK]) |=> !status[BIT_LINK])
      else $error("write of one did not clear link error status");

   a_status_sticky: assert property ( // see R15
      hotRst ##0 s_quiet |=> status == $past(status))
      else $error("status changed across hot reset");

   a_mask_write: assert property ( // see R9
      (wrReq && addr_is(wrAddr, MASK_OFF) && wrStrb[0] && !hotRst) |=>
      mask[BIT_LINK] == $past(wrBits[BIT_LINK]))
      else $error("link error mask bit did not take written value");

   a_unmapped_read: assert property ( // see R15
      (rdReq && !rdHit) |=>
      rvalid && rdata == 32'h0000_0000 && rresp == RESP_SLVERR)
      else $error("unmapped read not answered with zero and error");

   a_unmapped_write: assert property ( // see R15
      (wrReq && !wrHit) |=> bvalid && bresp == RESP_SLVERR)
      else $error("unmapped write not answered with error");

   a_link_sticky: assert property ( // see R14
      status[BIT_LINK] ##0 s_no_status_write |=> status[BIT_LINK])
      else $error("link error status dropped without a clear");

   a_sticky_mask: assert property ( // see R9 see R10 see R13
      hotRst |=> (mask & MASK_STICKY) == $past(mask & MASK_STICKY))
      else $error("sticky mask bits lost on hot reset");

   a_timeout_clear: assert property ( // see R11
      hotRst |=> mask[BIT_CTO] == 1'b0)
      else $error("completion timeout mask kept across hot reset");

   a_ro_mask: assert property ( // see R12 see R15
      (mask & ~MASK_RW) == 32'h0000_0000)
      else $error("read-only mask position became set");

endmodule : aum_regs

// file: tb/aum_root_model.sv
`timescale 1ns/1ps
// root-complex side: counts reports and keeps the last pointer seen
module aum_root_model
   import aum_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire aum_report_t errReport,
   output int reportCount,
   output logic [4:0] lastPointer
);
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reportCount <= 0;
         lastPointer <= 5'h00;
      end else if (errReport.valid) begin
         // one pulse is one message, so held hits count per cycle
         reportCount <= reportCount + 1;
         lastPointer <= errReport.pointer;
      end
   end
endmodule : aum_root_model

// file: tb/aum_regs_bench.sv
`timescale 1ns/1ps
module aum_regs_bench
   import aum_pkg::*;
;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hotRst = 1'b0;
   aum_err_t errIn = '0;
   aum_report_t errReport;
   logic irq;
   logic [11:0] awaddr = 12'h000;
   logic awvalid = 1'b0;
   logic awready;
   logic [31:0] wdata = 32'h0000_0000;
   logic wvalid = 1'b0;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready = 1'b0;
   logic [11:0] araddr = 12'h000;
   logic arvalid = 1'b0;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready = 1'b0;
   int miscompares = 0;
   int checksDone = 0;
   int reportCount;
   int base;
   logic [4:0] lastPointer;
   logic [31:0] rdVal;
   logic [1:0] rdResp;
   logic [1:0] wrResp;
   localparam logic [31:0] HDR_A = 32'hA5A5_0001;

   aum_regs #(.ADDR_W(12)) i_dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .hotRst(hotRst),
      .errIn(errIn), .errReport(errReport), .irq(irq),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
   );

   aum_root_model i_root (
      .core_clk(core_clk), .sys_rst(sys_rst), .errReport(errReport),
      .reportCount(reportCount), .lastPointer(lastPointer)
   );

   initial begin
      forever #4 core_clk = ~core_clk;
   end

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checksDone, miscompares);
      if (miscompares == 0 && checksDone > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   // the wait is bounded; a hung handshake ends the run as a failure
   task automatic tick(inout int n);
      @(posedge core_clk);
      n++;
      if (n > 100) begin
         miscompares++;
         finish_test();
      end
   endtask : tick

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         tick(n);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      bready <= 1'b0;
      wrResp = bresp;
   endtask : wr

   task automatic rd(input logic [11:0] a);
      int n;
      n = 0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         tick(n);
         if (arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      rready <= 1'b0;
      rdVal = rdata;
      rdResp = rresp;
   endtask : rd

   task automatic pulse(input logic [31:0] h, input logic [31:0] hdr);
      @(posedge core_clk);
      errIn <= '{hit: h, header: hdr};
      @(posedge core_clk);
      errIn <= '0;
      repeat (3) @(posedge core_clk);
   endtask : pulse

   task automatic t_reset();
      rd(STATUS_OFF);
      chk(rdVal, 32'h0000_0000);
      rd(MASK_OFF);
      chk(rdVal, 32'h0000_0000);
      rd(12'h0F0);
      chk({rdVal[31:2], rdResp}, 32'h0000_0002);
      wr(12'h0F0, 32'hFFFF_FFFF);
      chk({30'h0000_0000, wrResp}, 32'h0000_0002);
   endtask : t_reset

   task automatic t_mask_rw();
      wr(MASK_OFF, 32'hFFFF_FFFF);
      chk({30'h0000_0000, wrResp}, 32'h0000_0000);
      rd(MASK_OFF);
      chk(rdVal, 32'h0001_5011);
      chk({30'h0000_0000, rdResp}, 32'h0000_0000);
      wr(MASK_OFF, 32'h0000_0000);
      rd(MASK_OFF);
      chk(rdVal, 32'h0000_0000);
   endtask : t_mask_rw

   // read-only and reserved positions are hit together with real ones
   task automatic t_events();
      base = reportCount;
      pulse(32'h03C1_F034, HDR_A);
      rd(STATUS_OFF);
      chk(rdVal, 32'h0001_5010);
      chk(32'(reportCount - base), 32'h0000_0001);
      chk({27'h000_0000, lastPointer}, 32'h0000_0004);
      rd(FEP_OFF);
      chk(rdVal, 32'h0000_0004);
      rd(HDR_OFF);
      chk(rdVal, HDR_A);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
   endtask : t_events

   task automatic t_clear();
      wr(STATUS_OFF, 32'h0000_0010);
      rd(STATUS_OFF);
      chk(rdVal, 32'h0001_5000);
      wr(STATUS_OFF, 32'hFFFF_FFFF);
      rd(STATUS_OFF);
      chk(rdVal, 32'h0000_0000);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
   endtask : t_clear

   task automatic t_masked();
      wr(MASK_OFF, 32'h0000_1010);
      base = reportCount;
      pulse(32'h0000_1010, 32'h5A5A_0002);
      rd(STATUS_OFF);
      chk(rdVal, 32'h0000_1010);
      chk(32'(reportCount - base), 32'h0000_0000);
      rd(FEP_OFF);
      chk(rdVal, 32'h0000_0004);
      rd(HDR_OFF);
      chk(rdVal, HDR_A);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      wr(STATUS_OFF, 32'h0000_0010);
      rd(STATUS_OFF);
      chk(rdVal, 32'h0000_1000);
   endtask : t_masked

   task automatic t_internal();
      pulse(32'h0040_0000, 32'h0000_0003);
      rd(STATUS_OFF);
      chk(rdVal, 32'h0000_1000);
      wr(CTRL_OFF, 32'h0000_0001);
      base = reportCount;
      pulse(32'h0040_0000, 32'h0000_0003);
      rd(STATUS_OFF);
      chk(rdVal, 32'h0040_1000);
      chk(32'(reportCount - base), 32'h0000_0001);
      chk({27'h000_0000, lastPointer}, 32'h0000_0016);
      wr(CTRL_OFF, 32'h0000_0000);
      rd(STATUS_OFF);
      chk(rdVal, 32'h0000_1000);
   endtask : t_internal

   task automatic t_hot();
      wr(MASK_OFF, 32'hFFFF_FFFF);
      @(posedge core_clk);
      hotRst <= 1'b1;
      @(posedge core_clk);
      hotRst <= 1'b0;
      rd(MASK_OFF);
      chk(rdVal, 32'h0001_1011);
      rd(STATUS_OFF);
      chk(rdVal, 32'h0000_1000);
      rd(FEP_OFF);
      chk(rdVal, 32'h0000_0016);
   endtask : t_hot

   initial begin
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_mask_rw();
      t_events();
      t_clear();
      t_masked();
      t_internal();
      t_hot();
      finish_test();
   end
endmodule : aum_regs_bench
